// >>> logic/pbs_burst_counter.sv
`timescale 1ns/100ps
`default_nettype none
module pbs_burst_counter
  import pbs_pkg::*;
(
  input  wire logic  core_clk_in,
  input  wire logic  reset_n_in,
  pbs_burst_if.ctr   bi
);

  typedef struct packed {
    logic [PBS_OFS_W-1:0] start;
    logic [PBS_OFS_W-1:0] beat;
  } pbs_ctr_t;

  pbs_ctr_t state;
  pbs_ctr_t next_state;

  function automatic logic [PBS_OFS_W-1:0] pbs_order(
    input logic [PBS_OFS_W-1:0] s,
    input logic [PBS_OFS_W-1:0] c,
    input logic                 lin_n
  );
    pbs_order = lin_n ? (s ^ c) : PBS_OFS_W'(s + c);
  endfunction

  always_comb begin
    next_state = state;
    if (bi.load) begin
      next_state.start = bi.start;
      next_state.beat  = PBS_BEAT_0;
    end else if (bi.advance) begin
      next_state.beat = PBS_OFS_W'(state.beat + PBS_OFS_STEP);
    end
  end

  assign bi.cur  = pbs_order(state.start, state.beat, bi.linear_n);
  assign bi.step = pbs_order(state.start,
                             PBS_OFS_W'(state.beat + PBS_OFS_STEP),
                             bi.linear_n);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// >>> logic/pbs_burst_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pbs_burst_if;
  import pbs_pkg::*;
  logic                 load;
  logic                 advance;
  logic                 linear_n;
  logic [PBS_OFS_W-1:0] start;
  logic [PBS_OFS_W-1:0] cur;
  logic [PBS_OFS_W-1:0] step;

  modport ctrl (output load, output advance, output linear_n,
                output start, input cur, input step);
  modport ctr  (input load, input advance, input linear_n,
                input start, output cur, output step);
endinterface
`default_nettype wire

// >>> logic/pbs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
      $error("pbs_fifo: depth must be a power of two, two or more");
    end
  end

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
  } pbs_fifo_t;

  pbs_fifo_t        state;
  pbs_fifo_t        next_state;
  logic [WIDTH-1:0] store [DEPTH];
  logic             push;
  logic             pop;

  always_comb begin
    in_ready_out  = (state.count != (PW+1)'(DEPTH));
    out_valid_out = (state.count != '0);
    out_data_out  = store[state.rd_ptr];
    push          = in_valid_in && in_ready_out;
    pop           = out_ready_in && out_valid_out;
    next_state    = state;
    if (push) begin
      next_state.wr_ptr = PW'(state.wr_ptr + 1'b1);
    end
    if (pop) begin
      next_state.rd_ptr = PW'(state.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_state.count = (PW+1)'(state.count + 1'b1);
    end else if (pop && !push) begin
      next_state.count = (PW+1)'(state.count - 1'b1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      store[state.wr_ptr] <= in_data_in;
    end
  end

endmodule
`default_nettype wire

// >>> logic/pbs_pkg.sv
`default_nettype none
package pbs_pkg;

  // ------------------------------------------------------------
  // array shape and data lanes
  // ------------------------------------------------------------
  localparam int   PBS_ADDR_W     = 17;
  localparam int   PBS_LANES      = 4;
  localparam int   PBS_LANE_W     = 8;
  localparam int   PBS_BYTE_BITS  = PBS_LANES * PBS_LANE_W;
  localparam int   PBS_DATA_W     = PBS_BYTE_BITS + PBS_LANES;
  localparam int   PBS_OFS_W      = 2;
  localparam int   PBS_FIFO_DEPTH = 32;

  // ------------------------------------------------------------
  // pipeline and burst constants
  // ------------------------------------------------------------
  localparam logic [1:0] PBS_PIPE_LAT = 2'h2;
  localparam logic [1:0] PBS_FILL_ONE = 2'h1;
  localparam logic [1:0] PBS_OFS_STEP = 2'h1;
  localparam logic [1:0] PBS_BEAT_0   = 2'h0;

  typedef enum logic [1:0] {
    PBS_IDLE     = 2'b00,
    PBS_BURST_RD = 2'b01,
    PBS_BURST_WR = 2'b10
  } pbs_mode_t;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [PBS_ADDR_W-1:0] addr;
    logic [PBS_LANES-1:0]  strobe_n;
  } pbs_op_t;

endpackage
`default_nettype wire

// >>> logic/pbs_sram_core.sv
`timescale 1ns/100ps
`default_nettype none
module pbs_sram_core
  import pbs_pkg::*;
#(
  parameter int ADDR_W     = PBS_ADDR_W,
  parameter int FIFO_DEPTH = PBS_FIFO_DEPTH
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  clock_enable_n_in,
  input  wire logic [ADDR_W-1:0]     address_in,
  input  wire logic                  read_not_write_in,
  input  wire logic                  advance_not_load_in,
  input  wire logic                  select_a_n_in,
  input  wire logic                  select_b_in,
  input  wire logic                  select_c_n_in,
  input  wire logic [PBS_LANES-1:0]  byte_write_strobe_n_in,
  input  wire logic                  linear_order_n_in,
  input  wire logic                  output_enable_n_in,
  input  wire logic [PBS_DATA_W-1:0] data_in,
  output logic [PBS_DATA_W-1:0]      data_out,
  output logic                       data_oe_n_out
);

  initial begin
    if (ADDR_W != PBS_ADDR_W) begin
      $error("pbs_sram_core: address width must match the op type");
    end
    if (FIFO_DEPTH < int'(PBS_PIPE_LAT)) begin
      $error("pbs_sram_core: fifo cannot hold the pipeline");
    end
  end

  localparam int OP_W = $bits(pbs_op_t);
  localparam int HI_W = ADDR_W - PBS_OFS_W;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pbs_mode_t             mode;
    logic [HI_W-1:0]       base_hi;
    logic [1:0]            fill;
    logic                  drive;
    logic [PBS_DATA_W-1:0] dout;
  } pbs_core_t;

  pbs_core_t             state;
  pbs_core_t             next_state;
  logic [PBS_DATA_W-1:0] mem [2**ADDR_W];

  pbs_op_t     push_op;
  pbs_op_t     pop_op;
  logic [OP_W-1:0] pop_bits;
  logic        push_ready;
  logic        pop_valid;
  logic        en;
  logic        sel;
  logic        ld;
  logic        pop;

  pbs_burst_if bi();

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  // a stalled fifo counts as a suspended edge
  assign en  = !clock_enable_n_in && push_ready;
  assign sel = !select_a_n_in && select_b_in && !select_c_n_in;
  assign ld  = !advance_not_load_in;

  assign bi.load     = en && ld && sel;
  assign bi.advance  = en && !ld;
  assign bi.linear_n = linear_order_n_in;
  assign bi.start    = address_in[PBS_OFS_W-1:0];

  assign pop_op = pbs_op_t'(pop_bits);
  assign pop    = en && (state.fill == PBS_PIPE_LAT) && pop_valid;

  always_comb begin
    next_state = state;
    push_op    = '0;
    if (ld && sel) begin
      push_op.valid    = 1'b1;
      push_op.write    = !read_not_write_in;
      push_op.addr     = address_in;
      push_op.strobe_n = byte_write_strobe_n_in;
      next_state.mode  = read_not_write_in ? PBS_BURST_RD : PBS_BURST_WR;
      next_state.base_hi = address_in[ADDR_W-1:PBS_OFS_W];
    end else if (ld) begin
      next_state.mode = PBS_IDLE;
    end else begin
      case (state.mode)
        PBS_BURST_RD, PBS_BURST_WR: begin
          push_op.valid    = 1'b1;
          push_op.write    = (state.mode == PBS_BURST_WR);
          push_op.addr     = {state.base_hi, bi.step};
          push_op.strobe_n = byte_write_strobe_n_in;
        end
        PBS_IDLE: begin
          push_op.valid = 1'b0;
        end
        default: begin
          next_state.mode = PBS_IDLE;
        end
      endcase
    end
    if (state.fill != PBS_PIPE_LAT) begin
      next_state.fill = 2'(state.fill + PBS_FILL_ONE);
    end
    if (pop) begin
      // data cycle two edges after load
      // strobes play no part in reads
      next_state.drive = pop_op.valid && !pop_op.write;
      if (pop_op.valid && !pop_op.write) begin
        next_state.dout = mem[pop_op.addr];
      end
    end
    if (!en) begin
      next_state = state;
    end
  end

  // ------------------------------------------------------------
  // registers and array
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      // bus floats from the first edge
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (pop && pop_op.valid && pop_op.write) begin
      for (int i = 0; i < PBS_LANES; i++) begin
        // each lane on its own strobe
        if (!pop_op.strobe_n[i]) begin
          mem[pop_op.addr][i*PBS_LANE_W +: PBS_LANE_W] <=
            data_in[i*PBS_LANE_W +: PBS_LANE_W];
          mem[pop_op.addr][PBS_BYTE_BITS + i] <= data_in[PBS_BYTE_BITS + i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pipeline and burst counter
  // ------------------------------------------------------------
  // every enabled edge pushes one slot, so the fill stays at two
  pbs_fifo #(
    .WIDTH (OP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_pipe (
    .core_clk_in   (core_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (!clock_enable_n_in),
    .in_ready_out  (push_ready),
    .in_data_in    (push_op),
    .out_valid_out (pop_valid),
    .out_ready_in  (pop),
    .out_data_out  (pop_bits)
  );

  pbs_burst_counter u_burst (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .bi          (bi.ctr)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign data_out = state.dout;
  assign data_oe_n_out = !state.drive || output_enable_n_in;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_read_latency: assert property (
    (en && ld && sel && read_not_write_in) ##1 en ##1 en |=> state.drive)
    else $error("read data not driven two edges after load");

  a_deselect_hiz: assert property (
    (en && ld && !sel) ##1 en ##1 en |=> !state.drive)
    else $error("bus still driven two edges after deselect");

  a_suspend_hold: assert property (
    !en |=> state == $past(state))
    else $error("state changed on a suspended edge");

  a_reset_hiz: assert property (
    @(posedge core_clk_in) disable iff (1'b0)
    !reset_n_in |=> !state.drive && data_oe_n_out)
    else $error("bus driven right after reset");

  a_dir_held: assert property (
    en && !ld && state.mode != PBS_IDLE |=> state.mode == $past(state.mode))
    else $error("burst direction changed during advance");

  a_linear_step: assert property (
    (bi.load && !linear_order_n_in) ##1 (en && !ld)
    |=> bi.cur == 2'($past(address_in[PBS_OFS_W-1:0], 2) + 2'h1))
    else $error("linear burst did not step by one");

  a_interleave_two: assert property (
    (bi.load && linear_order_n_in) ##1 (en && !ld) ##1 (en && !ld)
    |=> bi.cur == ($past(address_in[PBS_OFS_W-1:0], 3) ^ 2'h2))
    else $error("interleaved third beat wrong");

  a_burst_wrap: assert property (
    bi.load ##1 (en && !ld) [*4]
    |=> bi.cur == $past(address_in[PBS_OFS_W-1:0], 5))
    else $error("burst did not wrap to start");

  a_no_select: assert property (
    en && ld && !sel |-> !push_op.valid && next_state.mode == PBS_IDLE)
    else $error("deselected load started an operation");

  a_noop_idle: assert property (
    en && !ld && state.mode == PBS_IDLE |-> !push_op.valid)
    else $error("advance while idle issued an operation");

  a_mask_none: assert property (
    pop && pop_op.valid && pop_op.write && (&pop_op.strobe_n)
    |=> mem[$past(pop_op.addr)] == $past(mem[pop_op.addr]))
    else $error("write with all strobes high changed memory");

  c_read_out: cover property (
    (en && ld && sel && read_not_write_in) ##1 en ##1 en ##1 state.drive);

  c_full_burst: cover property (bi.load ##1 (en && !ld) [*4]);

  c_suspend_burst: cover property (
    state.mode != PBS_IDLE && !en ##1 en && !ld);

endmodule
`default_nettype wire

// >>> sim/pbs_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbs_master_model
  import pbs_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clock_enable_n_in,
  input  wire logic             advance_not_load_in,
  input  wire logic             read_not_write_in,
  input  wire logic             select_a_n_in,
  input  wire logic             select_b_in,
  input  wire logic             select_c_n_in,
  output logic [PBS_DATA_W-1:0] data_out
);
  logic bact;
  logic bwr;
  logic w0;
  logic w1;
  int   seed = 74;
  wire  sel = !select_a_n_in && select_b_in && !select_c_n_in;

  initial data_out = '0;
  // ------------------------------------------------------------
  // write slot tracking
  // ------------------------------------------------------------
  // data two enabled edges on
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      {bact, bwr, w0, w1} <= '0;
    end else if (!clock_enable_n_in) begin
      w1 <= w0;
      if (!advance_not_load_in) begin
        bact <= sel;
        bwr  <= !read_not_write_in;
        w0   <= sel && !read_not_write_in;
      end else begin
        w0 <= bact && bwr;
      end
    end
  end
  // idle lanes toggle so a stale value never matches
  always @(negedge clk_in) begin
    data_out <= w1 ? {$random(seed), 4'($random(seed))} : ~data_out;
  end
endmodule
`default_nettype wire

// >>> sim/test_pipelined_burst_sram_core.sv
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_burst_sram_core;
  import pbs_pkg::*;
  // no-op until the first task call, so no read of an unwritten word
  logic clk = 0, rst_n = 0, cen_n = 0, rw = 1, adv = 1;
  logic a_n = 0, b = 1, c_n = 0, lin_n = 0, oe_n = 0;
  logic [PBS_ADDR_W-1:0]  addr = '0;
  logic [PBS_LANES-1:0]   strb = '0;
  wire logic [PBS_DATA_W-1:0] din;
  wire logic [PBS_DATA_W-1:0] dout;
  wire logic                  doe_n;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 74;
  logic [PBS_DATA_W-1:0] mem [int];
  logic [PBS_DATA_W-1:0] exp_q = '0;
  int pv[2] = '{0, 0}, pw[2], pa[2], ps[2];
  int bact = 0, bwr, base, beat, edrv = 0;

  always #25 clk = ~clk;

  pbs_sram_core dut (
    .core_clk_in(clk), .reset_n_in(rst_n), .clock_enable_n_in(cen_n),
    .address_in(addr), .read_not_write_in(rw),
    .advance_not_load_in(adv), .select_a_n_in(a_n),
    .select_b_in(b), .select_c_n_in(c_n),
    .byte_write_strobe_n_in(strb), .linear_order_n_in(lin_n),
    .output_enable_n_in(oe_n), .data_in(din), .data_out(dout),
    .data_oe_n_out(doe_n));

  pbs_master_model master (
    .clk_in(clk), .reset_n_in(rst_n), .clock_enable_n_in(cen_n),
    .advance_not_load_in(adv), .read_not_write_in(rw),
    .select_a_n_in(a_n), .select_b_in(b), .select_c_n_in(c_n),
    .data_out(din));

  task automatic chk(input logic [PBS_DATA_W-1:0] seen, exp,
                     input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s %h vs %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input logic c, d, r, input int ad,
                     input logic [2:0] s, input logic [3:0] w);
    @(negedge clk);
    cen_n = c;
    adv = d;
    rw = r;
    addr = PBS_ADDR_W'(ad);
    {a_n, b, c_n} = s;
    strb = w;
  endtask

  // five rows, one of them at the top of the array
  function automatic int mk(input int k);
    return ((k % 5 == 4) ? 'h1fffc : (k % 5) * 4) | ((k / 5) % 4);
  endfunction

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      pv = '{0, 0};
      bact = 0;
      edrv = 0;
    end else if (!cen_n) begin
      edrv = pv[1] && !pw[1];
      if (edrv) exp_q = mem[pa[1]];
      if (pv[1] && pw[1]) for (int i = 0; i < PBS_LANES; i++) begin
        if (!ps[1][i]) begin
          mem[pa[1]][8*i+:8] = din[8*i+:8];
          mem[pa[1]][32+i] = din[32+i];
        end
      end
      pv[1] = pv[0];
      pw[1] = pw[0];
      pa[1] = pa[0];
      ps[1] = ps[0];
      pv[0] = 0;
      ps[0] = strb;
      if (!adv) begin
        bact = !a_n && b && !c_n;
        if (bact) begin
          pv[0] = 1;
          pw[0] = !rw;
          bwr = !rw;
          base = addr;
          beat = 0;
          pa[0] = addr;
        end
      end else if (bact) begin
        beat = (beat + 1) % 4;
        pv[0] = 1;
        pw[0] = bwr;
        pa[0] = (base & ~3) | (lin_n ? (base ^ beat) & 3 : (base + beat) & 3);
      end
    end
    #10;
    chk(doe_n, !edrv || oe_n, "bus enable");
    if (edrv && !oe_n) chk(dout, exp_q, "read data");
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    $display("test reset done");
    for (int k = 0; k < 20; k++) cyc(0, 0, 0, mk(k), 3'b010, 4'h0);
    $display("test prefill done");
    // a load and six advances per burst so the wrap shows; rw flipped on advances
    for (int m = 0; m < 8; m++) begin
      cyc(0, 0, 1, 0, 3'b110, 4'h0);
      lin_n = m[0];
      cyc(0, 0, m[1], mk(6 * (m % 4) + 1), 3'b010, 4'($random(seed)));
      repeat (6) cyc(0, 1, !m[1], 0, 3'b101, 4'($random(seed)));
    end
    $display("test bursts done");
    for (int k = 0; k < 600; k++) begin
      cyc({$random(seed)} % 4 == 0, {$random(seed)} % 3 == 0,
          {$random(seed)} % 2, mk({$random(seed)} % 20),
          ({$random(seed)} % 8 < 5) ? 3'b010 : 3'($random(seed)),
          4'($random(seed)));
      oe_n = ({$random(seed)} % 8 == 0);
    end
    repeat (3) cyc(0, 0, 1, 0, 3'b000, 4'h0);
    $display("test random done");
    close_out;
  end

  initial begin
    #(50 * 2000);
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
